/* core/dtai_cfg.svh */
// constants for the threshold adjustment interval timer
// Overview of operation
// - low config bits pick remote interval
// - decrease wait 8 cycles doubling to 1024
// - increase wait doubles decrease, 16 to 2048
// - bits five to three pick on-chip interval
// - remote adjustments only while remote enable set
// - on-chip adjustments only while on-chip enable set
`ifndef DTAI_CFG_SVH
`define DTAI_CFG_SVH
`define DTAI_ADDR_W 4
`define DTAI_DATA_W 32
`define DTAI_CODE_W 3
`define DTAI_CNT_W 12
`define DTAI_OFS_CFG 4'h0
`define DTAI_OFS_CTRL 4'h4
`define DTAI_OFS_STAT 4'h8
`define DTAI_OFS_CNT_A 4'hC
`define DTAI_CFG_RST 8'h00
`define DTAI_CTRL_RST 2'h0
`define DTAI_CFG_W 8
`define DTAI_CTRL_W 2
`define DTAI_REM_LSB 0
`define DTAI_REM_MSB 2
`define DTAI_LOC_LSB 3
`define DTAI_LOC_MSB 5
`define DTAI_EN_REM_BIT 0
`define DTAI_EN_LOC_BIT 1
`define DTAI_BE_LOW 0
`define DTAI_DEC_BASE 12'h008
`define DTAI_INC_BASE 12'h010
`define DTAI_CNT_MAX 12'h800
`define DTAI_CNT_ONE 12'h001
`define DTAI_CNT_ZERO 12'h000
`define DTAI_ZERO32 32'h0000_0000
`endif

/* core/dtai_pkg.sv */
// types shared by the threshold adjustment interval timer
package dtai_pkg;
   typedef logic [2:0] dtai_code_t;
   typedef logic [11:0] dtai_cnt_t;
   typedef enum logic {DTAI_IDLE, DTAI_ACK} dtai_bus_st_t;
endpackage

/* core/dtai_top.sv */
// interval timer pacing fan-start threshold adjustments, avalon-mm slave
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dtai_cfg.svh"
module dtai_top
   import dtai_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic mon_tick_i,
   input wire logic remote_a_adjusted_i,
   input wire logic onchip_adjusted_i,
   output logic remote_a_dec_allow_o,
   output logic remote_a_inc_allow_o,
   output logic onchip_dec_allow_o,
   output logic onchip_inc_allow_o
);

   // decrease wait: base of eight cycles doubled per code step
   // twelve count bits hold even the longest increase wait, at code seven
   function automatic dtai_cnt_t dec_wait(input dtai_code_t code);
      dec_wait = dtai_cnt_t'(`DTAI_DEC_BASE << code);
   endfunction

   // increase wait is always twice the decrease wait
   function automatic dtai_cnt_t inc_wait(input dtai_code_t code);
      inc_wait = dtai_cnt_t'(dec_wait(code) << 1);
   endfunction

   // next counter value: restart wins over a tick, saturates at longest wait
   // saturating keeps a channel that is never adjusted from wrapping to zero
   function automatic dtai_cnt_t cnt_next(input dtai_cnt_t cnt, input logic en,
                                          input logic adj, input logic tick);
      if (adj || !en) begin
         cnt_next = `DTAI_CNT_ZERO;
      end else if (tick && cnt < `DTAI_CNT_MAX) begin
         cnt_next = dtai_cnt_t'(cnt + `DTAI_CNT_ONE);
      end else begin
         cnt_next = cnt;
      end
   endfunction

   logic [7:0] cfg_ff; // interval codes, top two bits reserved
   logic [1:0] ctrl_ff; // dynamic floor enables
   dtai_cnt_t cnt_a_ff; // remote monitoring cycles since adjust
   dtai_cnt_t cnt_l_ff; // on-chip monitoring cycles since adjust
   dtai_bus_st_t bus_st_ff; // bus handshake state
   logic [31:0] rdata_ff;
   logic wait_ff;
   logic dec_a_ff, inc_a_ff, dec_l_ff, inc_l_ff;

   // decoded fields and addresses
   wire dtai_code_t remote_a_adjust_interval =
      cfg_ff[`DTAI_REM_MSB:`DTAI_REM_LSB];
   wire dtai_code_t onchip_adjust_interval =
      cfg_ff[`DTAI_LOC_MSB:`DTAI_LOC_LSB];
   wire remote_a_dynamic_floor_en = ctrl_ff[`DTAI_EN_REM_BIT];
   wire onchip_dynamic_floor_en = ctrl_ff[`DTAI_EN_LOC_BIT];
   wire req = avs_read_i || avs_write_i;
   wire take = req && (bus_st_ff == DTAI_IDLE);
   wire commit = req && (bus_st_ff == DTAI_ACK);
   wire wr_low = avs_write_i && commit && avs_byteenable_i[`DTAI_BE_LOW];
   wire sel_cfg = (avs_address_i == `DTAI_OFS_CFG);
   wire sel_ctrl = (avs_address_i == `DTAI_OFS_CTRL);
   wire sel_stat = (avs_address_i == `DTAI_OFS_STAT);
   wire sel_cnt = (avs_address_i == `DTAI_OFS_CNT_A);
   // config value the register holds after this edge
   wire logic [`DTAI_CFG_W-1:0] nxt_cfg = (wr_low && sel_cfg) ?
      avs_writedata_i[`DTAI_CFG_W-1:0] : cfg_ff;
   wire dtai_code_t nxt_rem_code = nxt_cfg[`DTAI_REM_MSB:`DTAI_REM_LSB];
   wire dtai_code_t nxt_loc_code = nxt_cfg[`DTAI_LOC_MSB:`DTAI_LOC_LSB];

   // read mux; unmapped addresses read as zero and ignore writes
   logic [31:0] rd_mux;
   always_comb begin
      if (sel_cfg) begin
         rd_mux = {24'h000000, 2'h0, cfg_ff[`DTAI_LOC_MSB:`DTAI_REM_LSB]};
      end else if (sel_ctrl) begin
         rd_mux = {30'h00000000, ctrl_ff};
      end else if (sel_stat) begin
         rd_mux = {28'h0000000, inc_l_ff, dec_l_ff, inc_a_ff, dec_a_ff};
      end else if (sel_cnt) begin
         rd_mux = {4'h0, cnt_l_ff, 4'h0, cnt_a_ff};
      end else begin
         rd_mux = `DTAI_ZERO32;
      end
   end

   // counters and permits
   wire dtai_cnt_t nxt_cnt_a = cnt_next(cnt_a_ff, remote_a_dynamic_floor_en,
                                        remote_a_adjusted_i, mon_tick_i);
   wire dtai_cnt_t nxt_cnt_l = cnt_next(cnt_l_ff, onchip_dynamic_floor_en,
                                        onchip_adjusted_i, mon_tick_i);
   // permits come from the next count so flag and counter never disagree
   // they also judge against the next codes: a code written while a channel
   // runs moves its permits on the same edge as the register, never a cycle late
   wire nxt_dec_a = remote_a_dynamic_floor_en && !remote_a_adjusted_i &&
                    nxt_cnt_a >= dec_wait(nxt_rem_code);
   wire nxt_inc_a = remote_a_dynamic_floor_en && !remote_a_adjusted_i &&
                    nxt_cnt_a >= inc_wait(nxt_rem_code);
   wire nxt_dec_l = onchip_dynamic_floor_en && !onchip_adjusted_i &&
                    nxt_cnt_l >= dec_wait(nxt_loc_code);
   wire nxt_inc_l = onchip_dynamic_floor_en && !onchip_adjusted_i &&
                    nxt_cnt_l >= inc_wait(nxt_loc_code);

   // bus handshake: one wait cycle then a single ack cycle
   // read data is captured when a request is taken and held until the next one
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         bus_st_ff <= DTAI_IDLE;
         wait_ff <= 1'b1;
         rdata_ff <= `DTAI_ZERO32;
      end else if (take) begin
         bus_st_ff <= DTAI_ACK;
         wait_ff <= 1'b0;
         rdata_ff <= rd_mux;
      end else begin
         bus_st_ff <= DTAI_IDLE;
         wait_ff <= 1'b1;
      end
   end

   // register writes land on the edge the master sees waitrequest low
   // reserved config bits are stored but never read back or used
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         cfg_ff <= `DTAI_CFG_RST;
         ctrl_ff <= `DTAI_CTRL_RST;
      end else if (wr_low && sel_cfg) begin
         cfg_ff <= nxt_cfg;
      end else if (wr_low && sel_ctrl) begin
         ctrl_ff <= avs_writedata_i[`DTAI_CTRL_W-1:0];
      end
   end

   // monitoring-cycle counters, one per channel
   // a disabled channel holds zero, so enabling always starts a full wait
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         cnt_a_ff <= `DTAI_CNT_ZERO;
         cnt_l_ff <= `DTAI_CNT_ZERO;
         dec_a_ff <= 1'b0;
         inc_a_ff <= 1'b0;
         dec_l_ff <= 1'b0;
         inc_l_ff <= 1'b0;
      end else begin
         cnt_a_ff <= nxt_cnt_a;
         cnt_l_ff <= nxt_cnt_l;
         dec_a_ff <= nxt_dec_a;
         inc_a_ff <= nxt_inc_a;
         dec_l_ff <= nxt_dec_l;
         inc_l_ff <= nxt_inc_l;
      end
   end

   // every output is a flip-flop, no logic after the registers
   assign avs_readdata_o = rdata_ff;
   assign avs_waitrequest_o = wait_ff;
   assign remote_a_dec_allow_o = dec_a_ff;
   assign remote_a_inc_allow_o = inc_a_ff;
   assign onchip_dec_allow_o = dec_l_ff;
   assign onchip_inc_allow_o = inc_l_ff;

   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   // a request seen while idle is answered by exactly one ack cycle
   sequence s_req_wait;
      req && avs_waitrequest_o && bus_st_ff == DTAI_IDLE;
   endsequence
   sequence s_ack_once;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence

   AST_BUS_ACK: assert property (s_req_wait |=> s_ack_once)
      else $error("bus ack not one cycle after request");
   // a committed config write must show up in both code fields next cycle
   AST_REM_FIELD: assert property (
      avs_write_i && !avs_waitrequest_o && sel_cfg && avs_byteenable_i[`DTAI_BE_LOW]
      |=> remote_a_adjust_interval == $past(avs_writedata_i[`DTAI_REM_MSB:`DTAI_REM_LSB]))
      else $error("remote interval field not written");
   AST_LOC_FIELD: assert property (
      avs_write_i && !avs_waitrequest_o && sel_cfg && avs_byteenable_i[`DTAI_BE_LOW]
      |=> onchip_adjust_interval == $past(avs_writedata_i[`DTAI_LOC_MSB:`DTAI_LOC_LSB]))
      else $error("on-chip interval field not written");
   // a decrease permit rises only as the count reaches the decrease wait,
   // or just after a code or enable write moved the goal post
   AST_DEC_WAIT: assert property (
      $rose(remote_a_dec_allow_o)
      |-> cnt_a_ff == (`DTAI_DEC_BASE << remote_a_adjust_interval)
          || $changed(cfg_ff) || $changed(ctrl_ff))
      else $error("remote decrease permit at wrong count");
   AST_LOC_DEC_WAIT: assert property (
      $rose(onchip_dec_allow_o)
      |-> cnt_l_ff == (`DTAI_DEC_BASE << onchip_adjust_interval)
          || $changed(cfg_ff) || $changed(ctrl_ff))
      else $error("on-chip decrease permit at wrong count");
   // a remote increase permit implies the remote decrease permit and the doubled wait
   AST_INC_TWICE: assert property (
      remote_a_inc_allow_o |-> remote_a_dec_allow_o &&
      cnt_a_ff >= (`DTAI_INC_BASE << remote_a_adjust_interval))
      else $error("remote increase permit before double wait");
   // a cleared enable forces both permits of its channel low
   AST_REM_EN: assert property (
      !remote_a_dynamic_floor_en |=> !remote_a_dec_allow_o && !remote_a_inc_allow_o)
      else $error("remote permit while disabled");
   AST_LOC_EN: assert property (
      !onchip_dynamic_floor_en |=> !onchip_dec_allow_o && !onchip_inc_allow_o)
      else $error("on-chip permit while disabled");
   // an adjustment pulse restarts its channel's wait from zero
   AST_RESTART: assert property (
      remote_a_adjusted_i |=> cnt_a_ff == `DTAI_CNT_ZERO && !remote_a_dec_allow_o)
      else $error("remote counter not restarted");
   AST_LOC_RESTART: assert property (
      onchip_adjusted_i |=> cnt_l_ff == `DTAI_CNT_ZERO && !onchip_inc_allow_o
                            && !onchip_dec_allow_o)
      else $error("on-chip counter not restarted");

endmodule

/* sim/testbench.sv */
// self-checking bench for the threshold adjustment interval timer
`timescale 1ns/1ps
module testbench;
   import dtai_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic mon_tick_i = 1'b0;
   logic remote_a_adjusted_i = 1'b0;
   logic onchip_adjusted_i = 1'b0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic rd_o, ri_o, ld_o, li_o;
   logic [31:0] exp_q[$]; // expected read data, oldest first
   logic [31:0] seed = 32'hB9442542;
   int failures = 0;
   int checked = 0;
   dtai_top i_dtai_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .mon_tick_i(mon_tick_i),
      .remote_a_adjusted_i(remote_a_adjusted_i), .onchip_adjusted_i(onchip_adjusted_i),
      .remote_a_dec_allow_o(rd_o), .remote_a_inc_allow_o(ri_o),
      .onchip_dec_allow_o(ld_o), .onchip_inc_allow_o(li_o));
   // clock generator, 5 ns period
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   // monitoring-cycle ticks, one-cycle pulses with a gap
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk_i);
         mon_tick_i <= 1'b1;
         @(posedge mclk_i);
         mon_tick_i <= 1'b0;
      end
   endtask
   // read data is judged at the edge where the ack is seen; a status read
   // also judges the four permit pins, which must agree with it
   always @(posedge mclk_i) begin
      logic [31:0] e;
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         e = exp_q.pop_front();
         check("readdata", avs_readdata_o, e);
         if (avs_address_i == 4'h8) begin
            check("allow pins", {28'h0, li_o, ld_o, ri_o, rd_o}, e);
         end
      end
   end
   // watchdog, far above the roughly 8500 cycles the run needs
   initial begin
      #400000;
      failures++;
      close_out();
   end
   // main sequence: every code on both channels with random enables
   initial begin
      logic [31:0] r;
      logic [1:0] en;
      logic [2:0] cd;
      logic [2:0] cl;
      int tg[4];
      int t;
      repeat (6) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h1, 32'h0); // unmapped reads zero
      for (int c = 0; c < 8; c++) begin
         cd = 3'(c);
         cl = cd ^ 3'h1; // on-chip code differs so swapped fields show
         r = rnd();
         en = (c == 0) ? 2'h3 : r[1:0];
         bus(1'b1, 4'h4, 32'h0, 4'hF);
         bus(1'b1, 4'h0, {r[31:6], cl, cd}, 4'hF);
         bus(1'b1, 4'h0, 32'h0, 4'hE); // dropped, lane 0 disabled
         rd(4'h0, {26'h0, cl, cd});
         bus(1'b1, 4'h4, {r[31:2], en}, 4'hF);
         tg = '{(8 << c) - 1, 8 << c, (16 << c) - 1, 16 << c};
         t = 0;
         foreach (tg[k]) begin
            tick(tg[k] - t);
            t = tg[k];
            rd(4'h8, {28'h0, en[1] & (t >= (16 << cl)), en[1] & (t >= (8 << cl)),
               en[0] & (t >= (16 << c)), en[0] & (t >= (8 << c))});
         end
         rd(4'hC, {4'h0, en[1] ? 12'(t) : 12'h0, 4'h0, en[0] ? 12'(t) : 12'h0});
         @(posedge mclk_i);
         remote_a_adjusted_i <= 1'b1;
         onchip_adjusted_i <= 1'b1;
         @(posedge mclk_i);
         remote_a_adjusted_i <= 1'b0;
         onchip_adjusted_i <= 1'b0;
         rd(4'h8, 32'h0);
         rd(4'hC, 32'h0);
      end
      repeat (2) @(posedge mclk_i);
      close_out();
   end
endmodule
